// *** hdl/blc_regs.sv ***
// backlight driver configuration and fault register bank
//
// Operation
// - sample rate and polarity from pwm bits 7:5
// - hysteresis field gives zero to six lsbs
// - pulse filter rejects below 100/150/200 ns
// - boost frequency select and minus twelve shift
// - overvoltage, current limit and inductor select fields
// - eight-bit auto-frequency thresholds compared to code
// - ceiling pin forces code msbs to ceiling register
// - low register holds code bits 2:0
// - high register holds code msbs, all ones
// - clear disable bit makes fault force shutdown; led short never does
// - fault flags read as ones, reserved zero
// - refuse re-enable until fault flags read back
// - reserved and unmapped reads return zero
// - device enable rising restores pwm defaults
`timescale 1ns/10ps
module blc_regs #(
  parameter logic [6:0] DEV_ADDR = blc_pkg::DEV_ADDR_DFLT
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_device_enable,
  input wire logic i_ceiling_force_input,
  input wire logic i_overvoltage_protect,
  input wire logic i_string_open,
  input wire logic i_led_short,
  input wire logic i_current_limit_protect,
  input wire logic i_thermal_shutdown,
  output logic [14:0] o_pwm_sample_khz,
  output logic o_pwm_active_high,
  output logic [2:0] o_pwm_hyst_lsbs,
  output logic [4:0] o_pulse_filter_cycles,
  output logic o_boost_freq_1mhz,
  output logic o_boost_no_shift,
  output logic o_inductor_22uh,
  output logic [1:0] o_ovp_sel,
  output logic [1:0] o_ocp_sel,
  output logic [blc_pkg::CODE_W-1:0] o_brightness_code,
  output logic o_af_above_upper,
  output logic o_af_below_lower,
  output logic o_short_detect_en,
  output logic o_fault_shutdown,
  output logic o_reenable_blocked
);
  import blc_pkg::*;

  logic wr_stb, rd_stb;
  logic [7:0] addr, wr_data, rd_addr, rd_data;
  logic [5:0] sync1_ff, sync2_ff;
  logic ceil_sync;
  logic [FLAG_W-1:0] raw_fault, fault_now, shut_mask, flag_ff;
  logic [7:0] pwm_ff, af_hi_ff, af_lo_ff, ceil_ff, br_hi_ff;
  logic [6:0] boost_ff;
  logic [2:0] br_lo_ff;
  logic [3:0] fcfg_ff;
  logic en_q_ff, en_rise, rd_flt, shut_evt, pending_ff;
  logic [CODE_W-1:0] code;

  blc_i2c_tgt #(.DEV_ADDR(DEV_ADDR)) u_tgt (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .o_wr_stb(wr_stb),
    .o_addr(addr),
    .o_wr_data(wr_data),
    .o_rd_stb(rd_stb),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data)
  );

  // pins from outside the clock domain
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
    end else begin
      sync1_ff <= {i_ceiling_force_input, i_string_open, i_led_short, i_thermal_shutdown,
                   i_current_limit_protect, i_overvoltage_protect};
      sync2_ff <= sync1_ff;
    end
  end

  assign ceil_sync = sync2_ff[5];
  assign raw_fault = sync2_ff[4:0];
  assign fault_now = {raw_fault[4], raw_fault[3] & fcfg_ff[FCFG_SHORT_EN], raw_fault[2:0]};
  assign shut_mask = {~fcfg_ff[FCFG_OVP], 1'b0, ~fcfg_ff[FCFG_TSD], ~fcfg_ff[FCFG_OCP],
                      ~fcfg_ff[FCFG_OVP]};
  assign en_rise = i_device_enable & ~en_q_ff;
  assign rd_flt = rd_stb && (rd_addr == REG_FLT);
  assign shut_evt = |(fault_now & shut_mask);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      en_q_ff <= 1'b0;
    end else begin
      en_q_ff <= i_device_enable;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      pwm_ff <= RST_PWM;
    end else if (en_rise) begin
      pwm_ff <= RST_PWM;
    end else if (wr_stb && addr == REG_PWM) begin
      pwm_ff <= wr_data;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      boost_ff <= RST_BOOST;
      af_hi_ff <= RST_AF;
      af_lo_ff <= RST_AF;
      ceil_ff <= RST_CEIL;
      br_lo_ff <= RST_BR_LO;
      br_hi_ff <= RST_BR_HI;
      fcfg_ff <= RST_FLT_CFG;
    end else if (wr_stb) begin
      case (addr)
        REG_BOOST: boost_ff <= wr_data[6:0];
        REG_AF_HI: af_hi_ff <= wr_data;
        REG_AF_LO: af_lo_ff <= wr_data;
        REG_CEIL: ceil_ff <= wr_data;
        REG_BR_LO: br_lo_ff <= wr_data[2:0];
        REG_BR_HI: br_hi_ff <= wr_data;
        REG_FLT_CFG: fcfg_ff <= wr_data[3:0];
        default: ;
      endcase
    end
  end

  // set wins over the read clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      flag_ff <= RST_FLAGS;
    end else begin
      flag_ff <= fault_now | (rd_flt ? RST_FLAGS : flag_ff);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_fault_shutdown <= 1'b0;
      pending_ff <= 1'b0;
    end else begin
      if (shut_evt) begin
        o_fault_shutdown <= 1'b1;
      end else if (en_rise && !pending_ff) begin
        o_fault_shutdown <= 1'b0;
      end
      if (shut_evt) begin
        pending_ff <= 1'b1;
      end else if (rd_flt) begin
        pending_ff <= 1'b0;
      end
    end
  end

  assign o_reenable_blocked = pending_ff;

  // reserved bits and unmapped offsets read zero
  always_comb begin
    rd_data = 8'h00;
    case (addr)
      REG_PWM: rd_data = pwm_ff;
      REG_BOOST: rd_data = {1'b0, boost_ff};
      REG_AF_HI: rd_data = af_hi_ff;
      REG_AF_LO: rd_data = af_lo_ff;
      REG_CEIL: rd_data = ceil_ff;
      REG_BR_LO: rd_data = {5'h00, br_lo_ff};
      REG_BR_HI: rd_data = br_hi_ff;
      REG_FLT_CFG: rd_data = {4'h0, fcfg_ff};
      REG_FLT: rd_data = {3'h0, flag_ff};
      default: rd_data = 8'h00;
    endcase
  end

  assign code = ceil_sync ? {ceil_ff, br_lo_ff} : {br_hi_ff, br_lo_ff};

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_brightness_code <= {RST_BR_HI, RST_BR_LO};
      o_pwm_sample_khz <= RATE_MID_KHZ;
      o_pwm_hyst_lsbs <= HYST_NONE;
      o_pulse_filter_cycles <= FILT0_CYC;
      o_af_above_upper <= 1'b0;
      o_af_below_lower <= 1'b0;
    end else begin
      o_brightness_code <= code;
      if (pwm_ff[PWM_RATE_LSB+1]) begin
        o_pwm_sample_khz <= RATE_HI_KHZ;
      end else if (pwm_ff[PWM_RATE_LSB]) begin
        o_pwm_sample_khz <= RATE_MID_KHZ;
      end else begin
        o_pwm_sample_khz <= RATE_LO_KHZ;
      end
      if (pwm_ff[PWM_HYST_LSB+:3] == HYST_INVALID) begin
        o_pwm_hyst_lsbs <= HYST_NONE;
      end else begin
        o_pwm_hyst_lsbs <= pwm_ff[PWM_HYST_LSB+:3];
      end
      unique case (pwm_ff[PWM_FILT_LSB+:2])
        2'b00: o_pulse_filter_cycles <= FILT0_CYC;
        2'b01: o_pulse_filter_cycles <= FILT1_CYC;
        2'b10: o_pulse_filter_cycles <= FILT2_CYC;
        2'b11: o_pulse_filter_cycles <= FILT3_CYC;
      endcase
      o_af_above_upper <= code[CODE_W-1:3] > af_hi_ff;
      o_af_below_lower <= code[CODE_W-1:3] < af_lo_ff;
    end
  end

  assign o_pwm_active_high = pwm_ff[PWM_POL_BIT];
  assign o_boost_freq_1mhz = boost_ff[BST_FREQ_BIT];
  assign o_boost_no_shift = boost_ff[BST_SHIFT_BIT];
  assign o_inductor_22uh = boost_ff[BST_IND_BIT];
  assign o_ovp_sel = boost_ff[BST_OVP_LSB+:2];
  assign o_ocp_sel = boost_ff[BST_OCP_LSB+:2];
  assign o_short_detect_en = fcfg_ff[FCFG_SHORT_EN];

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  chk_pwm_en_default: assert property (en_rise |=> pwm_ff == RST_PWM)
    else $error("pwm config not restored on enable");
  chk_hyst_invalid: assert property (
    pwm_ff[4:2] == HYST_INVALID |=> o_pwm_hyst_lsbs == 3'h0)
    else $error("invalid hysteresis not treated as none");
  chk_hyst_value: assert property (
    pwm_ff[4:2] != HYST_INVALID |=> o_pwm_hyst_lsbs == $past(pwm_ff[4:2]))
    else $error("hysteresis output wrong");
  chk_filter_max: assert property (
    pwm_ff[1:0] == 2'b11 |=> o_pulse_filter_cycles == 5'h14)
    else $error("200 ns filter count wrong");
  chk_ceiling_force: assert property (
    ceil_sync |=> o_brightness_code[10:3] == $past(ceil_ff))
    else $error("ceiling not forced");
  chk_code_plain: assert property (
    !ceil_sync |=> o_brightness_code == $past({br_hi_ff, br_lo_ff}))
    else $error("brightness code mismatch");
  chk_flag_clear: assert property (rd_flt && fault_now == 5'h00 |=> flag_ff == 5'h00)
    else $error("flags not cleared by read");
  chk_flag_sticky: assert property (!rd_flt && flag_ff[FLG_OCP] |=> flag_ff[FLG_OCP])
    else $error("flag lost without read");
  chk_shutdown_tsd: assert property (
    fault_now[FLG_TSD] && !fcfg_ff[FCFG_TSD] |=> o_fault_shutdown)
    else $error("thermal fault did not shut down");
  chk_reenable_refused: assert property (
    pending_ff && en_rise && !rd_flt |=> o_fault_shutdown ##1 o_reenable_blocked)
    else $error("re-enable accepted before flag read");
  chk_reserved_zero: assert property (addr == REG_BR_LO |-> rd_data[7:3] == 5'h00)
    else $error("reserved bits not zero");

  cov_reg_write: cover property (wr_stb && addr == REG_BR_HI);
  cov_flag_read: cover property (rd_flt && flag_ff != 5'h00);
  cov_shutdown: cover property ($rose(o_fault_shutdown));
  cov_ceiling: cover property (ceil_sync && wr_stb);
endmodule

// *** hdl/blc_pkg.sv ***
// constants shared by the backlight configuration register bank
package blc_pkg;
  localparam int DATA_W = 8;
  localparam int CODE_W = 11;
  localparam int FLAG_W = 5;

  localparam logic [7:0] REG_PWM = 8'h12;
  localparam logic [7:0] REG_BOOST = 8'h13;
  localparam logic [7:0] REG_AF_HI = 8'h15;
  localparam logic [7:0] REG_AF_LO = 8'h16;
  localparam logic [7:0] REG_CEIL = 8'h17;
  localparam logic [7:0] REG_BR_LO = 8'h18;
  localparam logic [7:0] REG_BR_HI = 8'h19;
  localparam logic [7:0] REG_FLT_CFG = 8'h1E;
  localparam logic [7:0] REG_FLT = 8'h1F;

  localparam logic [7:0] RST_PWM = 8'h73;
  localparam logic [6:0] RST_BOOST = 7'h6F;
  localparam logic [7:0] RST_AF = 8'h00;
  localparam logic [7:0] RST_CEIL = 8'h00;
  localparam logic [2:0] RST_BR_LO = 3'h7;
  localparam logic [7:0] RST_BR_HI = 8'hFF;
  localparam logic [3:0] RST_FLT_CFG = 4'h7;
  localparam logic [4:0] RST_FLAGS = 5'h00;

  localparam int PWM_RATE_LSB = 6;
  localparam int PWM_POL_BIT = 5;
  localparam int PWM_HYST_LSB = 2;
  localparam int PWM_FILT_LSB = 0;
  localparam logic [2:0] HYST_INVALID = 3'h7;
  localparam logic [2:0] HYST_NONE = 3'h0;

  localparam int BST_SHIFT_BIT = 6;
  localparam int BST_FREQ_BIT = 5;
  localparam int BST_IND_BIT = 4;
  localparam int BST_OVP_LSB = 2;
  localparam int BST_OCP_LSB = 0;

  localparam int FCFG_SHORT_EN = 3;
  localparam int FCFG_TSD = 2;
  localparam int FCFG_OCP = 1;
  localparam int FCFG_OVP = 0;

  localparam int FLG_OPEN = 4;
  localparam int FLG_SHORT = 3;
  localparam int FLG_TSD = 2;
  localparam int FLG_OCP = 1;
  localparam int FLG_OVP = 0;

  localparam int CLK_PERIOD_NS = 10;
  localparam int FILT1_NS = 100;
  localparam int FILT2_NS = 150;
  localparam int FILT3_NS = 200;
  localparam logic [4:0] FILT0_CYC = 5'h00;
  localparam logic [4:0] FILT1_CYC = 5'((FILT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] FILT2_CYC = 5'((FILT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [4:0] FILT3_CYC = 5'((FILT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [14:0] RATE_LO_KHZ = 15'h0320;
  localparam logic [14:0] RATE_MID_KHZ = 15'h0FA0;
  localparam logic [14:0] RATE_HI_KHZ = 15'h5DC0;

  localparam logic [6:0] DEV_ADDR_DFLT = 7'h36;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum logic [2:0] {
    BLC_IDLE = 3'b000,
    BLC_DEVADR = 3'b001,
    BLC_REGADR = 3'b010,
    BLC_WDATA = 3'b011,
    BLC_RDATA = 3'b100,
    BLC_IGNORE = 3'b101
  } blc_i2c_st_t;
endpackage

// *** hdl/blc_i2c_tgt.sv ***
// two-wire serial target: byte engine with register pointer
`timescale 1ns/10ps
module blc_i2c_tgt #(
  parameter logic [6:0] DEV_ADDR = blc_pkg::DEV_ADDR_DFLT
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_wr_stb,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data,
  output logic o_rd_stb,
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data
);
  import blc_pkg::*;

  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic scl_rise, scl_fall, start_det, stop_det;
  blc_i2c_st_t state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic drive_ff;
  logic rw_ff;
  logic active;

  // stage 0 feeds only stage 1; stage 2 is the previous stage-1 value
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], i_scl};
      sda_sync_ff <= {sda_sync_ff[1:0], i_sda};
    end
  end

  assign scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
  assign scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
  assign start_det = scl_sync_ff[1] & scl_sync_ff[2] & sda_sync_ff[2] & ~sda_sync_ff[1];
  assign stop_det = scl_sync_ff[1] & scl_sync_ff[2] & ~sda_sync_ff[2] & sda_sync_ff[1];
  assign active = (state_ff != BLC_IDLE) && (state_ff != BLC_IGNORE);
  assign o_sda_o = 1'b0;
  assign o_sda_oe = drive_ff;

  // address byte, register byte, then data bytes, each acknowledged
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_ff <= BLC_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      drive_ff <= 1'b0;
      rw_ff <= 1'b0;
      o_addr <= 8'h00;
      o_wr_data <= 8'h00;
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      o_rd_addr <= 8'h00;
    end else begin
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      if (start_det) begin
        state_ff <= BLC_DEVADR;
        // the start's own clock fall wraps the count to zero
        bit_cnt_ff <= 4'hf;
        drive_ff <= 1'b0;
      end else if (stop_det) begin
        state_ff <= BLC_IDLE;
        drive_ff <= 1'b0;
      end else if (scl_rise && active) begin
        if (bit_cnt_ff < BIT_ACK && state_ff != BLC_RDATA) begin
          shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
        end
        // master not-acknowledge ends the read burst
        if (state_ff == BLC_RDATA && bit_cnt_ff == BIT_ACK && sda_sync_ff[1]) begin
          state_ff <= BLC_IGNORE;
        end
      end else if (scl_fall && active) begin
        if (bit_cnt_ff == BIT_LAST) begin
          bit_cnt_ff <= BIT_ACK;
          unique case (state_ff)
            BLC_DEVADR: begin
              if (shift_ff[7:1] == DEV_ADDR) begin
                drive_ff <= 1'b1;
                rw_ff <= shift_ff[0];
              end else begin
                state_ff <= BLC_IGNORE;
              end
            end
            BLC_REGADR: begin
              o_addr <= shift_ff;
              drive_ff <= 1'b1;
            end
            BLC_WDATA: begin
              o_wr_data <= shift_ff;
              o_wr_stb <= 1'b1;
              drive_ff <= 1'b1;
            end
            BLC_RDATA: drive_ff <= 1'b0;
            BLC_IDLE, BLC_IGNORE: drive_ff <= 1'b0;
          endcase
        end else if (bit_cnt_ff == BIT_ACK) begin
          bit_cnt_ff <= 4'h0;
          drive_ff <= 1'b0;
          if ((state_ff == BLC_DEVADR && rw_ff) || state_ff == BLC_RDATA) begin
            state_ff <= BLC_RDATA;
            tx_ff <= i_rd_data;
            drive_ff <= ~i_rd_data[7];
            o_rd_stb <= 1'b1;
            o_rd_addr <= o_addr;
            o_addr <= o_addr + 8'h01;
          end else if (state_ff == BLC_DEVADR) begin
            state_ff <= BLC_REGADR;
          end else if (state_ff == BLC_REGADR) begin
            state_ff <= BLC_WDATA;
          end else begin
            o_addr <= o_addr + 8'h01;
          end
        end else begin
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
          if (state_ff == BLC_RDATA) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
            drive_ff <= ~tx_ff[6];
          end
        end
      end
    end
  end
endmodule

// *** verification/blc_host_mdl.sv ***
// two-wire bus master model that programs the register bank
`timescale 1ns/10ps
module blc_host_mdl #(
  parameter logic [6:0] ADDR = blc_pkg::DEV_ADDR_DFLT
) (
  input wire logic i_core_clk,
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  logic drv = 1'b1;
  initial o_scl = 1'b1;
  // open drain line, pulled up when nobody pulls low
  assign o_sda = drv & ~i_sda_oe;

  task automatic hp();
    repeat (5) @(negedge i_core_clk);
  endtask

  task automatic start();
    @(negedge i_core_clk);
    drv = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    drv = 1'b0;
    hp();
    o_scl = 1'b0;
  endtask

  task automatic stop();
    @(negedge i_core_clk);
    drv = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    drv = 1'b1;
    hp();
  endtask

  // data moves one cycle after the clock fall, sampled at the end of high
  task automatic xbit(input logic b, output logic r);
    @(negedge i_core_clk);
    drv = b;
    hp();
    o_scl = 1'b1;
    hp();
    r = o_sda;
    o_scl = 1'b0;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask

  // master nack after one byte ends the burst
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, r);
      d[i] = r;
    end
    xbit(1'b1, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    wbyte({ADDR, 1'b0}, k0);
    wbyte(a, k1);
    wbyte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    wbyte({ADDR, 1'b0}, k);
    wbyte(a, k);
    start();
    wbyte({ADDR, 1'b1}, k);
    rbyte(d);
    stop();
  endtask

  task automatic probe(input logic [6:0] ad, output logic ack);
    start();
    wbyte({ad, 1'b0}, ack);
    stop();
  endtask
endmodule

// *** verification/blc_regs_tb.sv ***
// self-checking bench for the backlight register bank
`timescale 1ns/10ps
module blc_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic ceil = 1'b0;
  logic [4:0] flt = 5'h00; // same bit order as the flag register
  logic scl, sda, sda_o, sda_oe;
  logic [14:0] rate;
  logic pol, f1m, nsh, ind, above, below, sden, sd, blk;
  logic [2:0] hyst;
  logic [4:0] filt;
  logic [1:0] overvoltage_protect, current_limit_protect;
  logic [10:0] code;
  int n_errors = 0;
  int checked = 0;

  always #5 clk = ~clk;

  blc_host_mdl blc_host_mdl_i (.i_core_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl),
    .o_sda(sda));

  blc_regs blc_regs_i (.i_core_clk(clk), .i_reset(rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_device_enable(en), .i_ceiling_force_input(ceil),
    .i_overvoltage_protect(flt[0]), .i_current_limit_protect(flt[1]),
    .i_thermal_shutdown(flt[2]), .i_led_short(flt[3]), .i_string_open(flt[4]),
    .o_pwm_sample_khz(rate), .o_pwm_active_high(pol), .o_pwm_hyst_lsbs(hyst),
    .o_pulse_filter_cycles(filt), .o_boost_freq_1mhz(f1m), .o_boost_no_shift(nsh),
    .o_inductor_22uh(ind), .o_ovp_sel(overvoltage_protect), .o_ocp_sel(current_limit_protect), .o_brightness_code(code),
    .o_af_above_upper(above), .o_af_below_lower(below), .o_short_detect_en(sden),
    .o_fault_shutdown(sd), .o_reenable_blocked(blk));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    blc_host_mdl_i.wr(a, d, ok);
    chk("ack", 16'(ok), 16'h0001);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    blc_host_mdl_i.rd(a, d);
    chk(nm, 16'(d), 16'(exp));
  endtask

  task automatic w8();
    repeat (8) @(negedge clk);
  endtask

  task automatic pulse_en();
    en = 1'b1;
    w8();
    en = 1'b0;
    w8();
  endtask

  task automatic t_defaults();
    logic [7:0] ad [9] = '{8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1E, 8'h1F};
    logic [7:0] ex [9] = '{8'h73, 8'h6F, 8'h00, 8'h00, 8'h00, 8'h07, 8'hFF, 8'h07, 8'h00};
    chk("rate", 16'(rate), 16'h0FA0);
    chk("pwm", 16'({pol, hyst, filt}), 16'h0194);
    chk("boost", 16'({nsh, f1m, ind, overvoltage_protect, current_limit_protect}), 16'h006F);
    chk("code", 16'(code), 16'h07FF);
    chk("fault", 16'({sden, sd}), 16'h0000);
    chk("sda_o", 16'(sda_o), 16'h0000);
    for (int i = 0; i < 9; i++) begin
      rchk("dflt", ad[i], ex[i]);
    end
  endtask

  task automatic t_pwm();
    logic [15:0] fc [4] = '{16'h0000, 16'h000A, 16'h000F, 16'h0014};
    for (int i = 0; i < 8; i++) begin
      logic [2:0] c;
      logic [7:0] v;
      c = 3'(i);
      v = {c[1:0], c[0], c, c[1:0]};
      wreg(8'h12, v);
      rchk("pwm_rd", 8'h12, v);
      chk("rate", 16'(rate), c[1] ? 16'h5DC0 : (c[0] ? 16'h0FA0 : 16'h0320));
      chk("pol", 16'(pol), 16'(c[0]));
      chk("hyst", 16'(hyst), (c == 3'h7) ? 16'h0000 : 16'(c));
      chk("filt", 16'(filt), fc[c[1:0]]);
    end
  endtask

  task automatic t_boost();
    logic [7:0] bv [3] = '{8'hFF, 8'h00, 8'h5A};
    for (int i = 0; i < 3; i++) begin
      wreg(8'h13, bv[i]);
      rchk("bst_rd", 8'h13, bv[i] & 8'h7F);
      chk("boost", 16'({nsh, f1m, ind, overvoltage_protect, current_limit_protect}), 16'(bv[i][6:0]));
    end
  endtask

  task automatic t_code();
    logic [7:0] up [3] = '{8'h10, 8'hA5, 8'hB0};
    logic [7:0] lo [3] = '{8'h20, 8'hA5, 8'hC0};
    logic [1:0] ex [3] = '{2'h2, 2'h0, 2'h1};
    wreg(8'h19, 8'hA5);
    wreg(8'h18, 8'hFA);
    rchk("lsb_rd", 8'h18, 8'h02);
    chk("code", 16'(code), 16'h052A);
    for (int i = 0; i < 3; i++) begin
      wreg(8'h15, up[i]);
      wreg(8'h16, lo[i]);
      w8();
      chk("autofreq", 16'({above, below}), 16'(ex[i]));
    end
    wreg(8'h17, 8'h3C);
    ceil = 1'b1;
    w8();
    chk("ceil_on", 16'(code), 16'h01E2);
    ceil = 1'b0;
    w8();
    chk("ceil_off", 16'(code), 16'h052A);
  endtask

  task automatic t_fault();
    int pin [4] = '{0, 1, 2, 4};
    int cb [4] = '{0, 1, 2, 0};
    flt = 5'h1F;
    w8();
    rchk("flg_noshort", 8'h1F, 8'h17);
    chk("no_sd", 16'(sd), 16'h0000);
    wreg(8'h1E, 8'h0F);
    chk("sden", 16'(sden), 16'h0001);
    flt = 5'h00;
    w8();
    rchk("flg_all", 8'h1F, 8'h1F);
    rchk("flg_clr", 8'h1F, 8'h00);
    for (int j = 0; j < 4; j++) begin
      wreg(8'h1E, 8'h07 & ~(8'h01 << cb[j]));
      flt = 5'h01 << pin[j];
      w8();
      flt = 5'h00;
      w8();
      chk("sd_blk", 16'({sd, blk}), 16'h0003);
      pulse_en();
      chk("sd_held", 16'(sd), 16'h0001);
      rchk("flg_one", 8'h1F, 8'h01 << pin[j]);
      chk("unblk", 16'(blk), 16'h0000);
      pulse_en();
      chk("sd_clr", 16'(sd), 16'h0000);
    end
    wreg(8'h1E, 8'h07);
  endtask

  task automatic t_misc();
    logic ack;
    wreg(8'h12, 8'h00);
    pulse_en();
    rchk("pwm_en", 8'h12, 8'h73);
    chk("rate_en", 16'(rate), 16'h0FA0);
    wreg(8'h20, 8'h55);
    rchk("unmapped", 8'h20, 8'h00);
    wreg(8'h1F, 8'hFF);
    rchk("flg_ro", 8'h1F, 8'h00);
    blc_host_mdl_i.probe(7'h35, ack);
    chk("wrong_adr", 16'(ack), 16'h0000);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_defaults();
    t_pwm();
    t_boost();
    t_code();
    t_fault();
    t_misc();
    wrap_up();
  end

  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
endmodule
